// file: bragu_consts.vh
// Constants for the bit-reversed and program-space address unit.
// Assumes inclusion by bare name; definitions only.
`ifndef BRAGU_CONSTS_VH
`define BRAGU_CONSTS_VH

// APB register byte offsets
`define BRAGU_OFF_BREV       12'h000
`define BRAGU_OFF_TABLE_PAGE     12'h004
`define BRAGU_OFF_VISPAG     12'h008
`define BRAGU_OFF_MODE       12'h00c
`define BRAGU_OFF_STATUS     12'h010

// Reset values
`define BRAGU_RST_BREV       16'h0000
`define BRAGU_RST_PAGE       8'h00
`define BRAGU_RST_MODE       16'h000f

// Field positions
`define BRAGU_BREV_EN_BIT    15
`define BRAGU_PTR_NONE       4'hf
`define BRAGU_MODE_XMODEN    15
`define BRAGU_PIVOT_MSB      14
`define BRAGU_PSEL_MSB       11
`define BRAGU_PSEL_LSB       8
`define BRAGU_PAGE_SPACE_BIT 7
`define BRAGU_WIN_EA_MSB     14
`define BRAGU_ERR_CNT_MAX    8'hff

// Addressing mode codes from the decoder
`define BRAGU_AM_DIRECT      3'h0
`define BRAGU_AM_IND         3'h1
`define BRAGU_AM_POSTINC     3'h2
`define BRAGU_AM_PREINC      3'h3
`define BRAGU_AM_POSTDEC     3'h4
`define BRAGU_AM_PREDEC      3'h5
`define BRAGU_AM_INDEXED     3'h6

// Table read kinds
`define BRAGU_TR_LOW         1'b0
`define BRAGU_TR_HIGH        1'b1

`endif

// file: bragu_top.v
// Address generation unit: bit-reversed X write addresses, table and
// visibility-window program addresses, and table read lane mapping.
// Assumes the decoder presents one request per cycle, held one cycle,
// and APB registers are written between instructions.
// Operation
// - Bit reversal only in X write unit, never on reads
// - Active when pointer select not 15, enable set, pre/post increment
// - Pointer and modifier both bit-reversed, added, sum reversed back
// - Other modes and byte accesses get normal addresses
// - Pivot modifier added to pointer; mode increment ignored
// - Pivot is 15 bits, scaled to word byte addresses
// - Reversed address LSB forced to zero
// - Reversal disables modulo on X writes; reads keep modulo
// - Table address is page byte joined with 16-bit EA
// - Page MSB zero selects user, one selects configuration
// - EA MSB set forms 23-bit address from page and EA low 15
// - EA bit 15 dropped; address bit 15 is page bit 0
// - Program address LSB from data address held at zero
// - Unaligned table accesses allowed; config reads allowed
// - Window is read-only and shows low program word only
// - Low word table read returns P15..0
// - Low byte read picks upper byte when byte select set
// - High word read returns P23..16, upper data byte zero
// - High byte read with byte select set returns zero
// - Program counter steps by two per program word
`timescale 1ns/1ps
`include "bragu_consts.vh"

module bragu_top #(
    parameter DW = 16,
    parameter PW = 24
) (
    input  wire          I_CORE_CLK,
    input  wire          I_SRST,
    // APB slave
    input  wire          I_PSEL,
    input  wire          I_PENABLE,
    input  wire          I_PWRITE,
    input  wire [11:0]   I_PADDR,
    input  wire [31:0]   I_PWDATA,
    output reg  [31:0]   O_PRDATA,
    output reg           O_PREADY,
    output reg           O_PSLVERR,
    // X write address request
    input  wire          I_WR_REQ,
    input  wire [3:0]    I_WR_PTR_SEL,
    input  wire [2:0]    I_WR_MODE,
    input  wire          I_WR_BYTE,
    input  wire [DW-1:0] I_WR_PTR,
    input  wire [DW-1:0] I_WR_OFFSET,
    output reg           O_WR_VALID,
    output reg  [DW-1:0] O_WR_EA,
    output reg  [DW-1:0] O_WR_PTR_NEXT,
    output reg           O_WR_BITREV,
    output reg           O_WR_MOD_ALLOW,
    // X read address request
    input  wire          I_RD_REQ,
    input  wire [DW-1:0] I_RD_PTR,
    input  wire [DW-1:0] I_RD_OFFSET,
    output reg           O_RD_VALID,
    output reg  [DW-1:0] O_RD_EA,
    output reg           O_RD_MOD_ALLOW,
    // Table operation address
    input  wire          I_TBL_REQ,
    input  wire          I_TBL_WRITE,
    input  wire [DW-1:0] I_TBL_EA,
    output reg           O_TBL_VALID,
    output reg  [PW-1:0] O_TBL_ADDR,
    output reg           O_TBL_CONFIG,
    output reg           O_TBL_WRITE,
    // Program space window
    input  wire          I_WIN_REQ,
    input  wire          I_WIN_WRITE,
    input  wire          I_WIN_ENABLE,
    input  wire [DW-1:0] I_WIN_EA,
    output reg           O_WIN_VALID,
    output reg  [PW-2:0] O_WIN_ADDR,
    output reg           O_WIN_WR_ERR,
    // Table read lane mapping
    input  wire          I_TRD_REQ,
    input  wire          I_TRD_HIGH,
    input  wire          I_TRD_BYTE,
    input  wire          I_TRD_BSEL,
    input  wire [PW-1:0] I_TRD_PWORD,
    output reg           O_TRD_VALID,
    output reg  [DW-1:0] O_TRD_DATA,
    // Program counter
    input  wire          I_PC_LOAD,
    input  wire [PW-1:0] I_PC_LOAD_VAL,
    input  wire          I_PC_STEP,
    output reg  [PW-1:0] O_PC
);

    // Software-visible state
    reg  [15:0]   brev_ctl_q;
    reg  [7:0]    table_page_q;
    reg  [7:0]    vis_page_q;
    reg  [15:0]   mode_ctl_q;
    reg  [7:0]    win_err_cnt_q;

    wire [3:0]    bitrev_pointer_select = mode_ctl_q[`BRAGU_PSEL_MSB:`BRAGU_PSEL_LSB];
    wire          bitrev_enable_bit     = brev_ctl_q[`BRAGU_BREV_EN_BIT];
    wire [14:0]   bitrev_pivot_modifier = brev_ctl_q[`BRAGU_PIVOT_MSB:0];

    // APB transfer completes in its access phase, zero wait states
    wire          apb_acc = I_PSEL & I_PENABLE;
    wire          apb_wr  = apb_acc & I_PWRITE;
    reg           addr_hit;
    reg  [31:0]   rd_mux;

    // Register read mux and address decode
    always @* begin
        addr_hit = 1'b1;
        rd_mux   = 32'h0000_0000;
        case (I_PADDR)
            `BRAGU_OFF_BREV:   rd_mux = {16'h0000, brev_ctl_q};
            `BRAGU_OFF_TABLE_PAGE: rd_mux = {24'h00_0000, table_page_q};
            `BRAGU_OFF_VISPAG: rd_mux = {24'h00_0000, vis_page_q};
            `BRAGU_OFF_MODE:   rd_mux = {16'h0000, mode_ctl_q};
            `BRAGU_OFF_STATUS: rd_mux = {24'h00_0000, win_err_cnt_q};
            default:           addr_hit = 1'b0;
        endcase
    end

    // APB outputs are registered; ready rises in the access phase
    always @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            O_PRDATA  <= 32'h0000_0000;
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY  <= I_PSEL & ~I_PENABLE;
            O_PSLVERR <= I_PSEL & ~I_PENABLE & ~addr_hit;
            O_PRDATA  <= (I_PSEL & ~I_PENABLE & ~I_PWRITE) ? rd_mux : 32'h0000_0000;
        end
    end

    // Register writes land on the edge where ready is sampled high
    always @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            brev_ctl_q   <= `BRAGU_RST_BREV;
            table_page_q <= `BRAGU_RST_PAGE;
            vis_page_q   <= `BRAGU_RST_PAGE;
            mode_ctl_q   <= `BRAGU_RST_MODE;
        end else if (apb_wr & O_PREADY) begin
            case (I_PADDR)
                `BRAGU_OFF_BREV:   brev_ctl_q   <= I_PWDATA[15:0];
                `BRAGU_OFF_TABLE_PAGE: table_page_q <= I_PWDATA[7:0];
                `BRAGU_OFF_VISPAG: vis_page_q   <= I_PWDATA[7:0];
                `BRAGU_OFF_MODE:   mode_ctl_q   <= I_PWDATA[15:0];
                default: ;
            endcase
        end
    end

    // Bit-reversed address path
    wire is_inc = (I_WR_MODE == `BRAGU_AM_PREINC) | (I_WR_MODE == `BRAGU_AM_POSTINC);
    wire is_pre = (I_WR_MODE == `BRAGU_AM_PREINC) | (I_WR_MODE == `BRAGU_AM_PREDEC);
    wire brev_active = (bitrev_pointer_select != `BRAGU_PTR_NONE) & bitrev_enable_bit
                       & is_inc & ~I_WR_BYTE & (I_WR_PTR_SEL == bitrev_pointer_select);

    // Pivot scaled to a byte address of word data
    wire [DW-1:0] pivot_bytes = {bitrev_pivot_modifier, 1'b0};

    // Reverse pointer and pivot, add normally, reverse back: carry runs MSB to LSB
    wire [DW-1:0] ptr_rev;
    wire [DW-1:0] piv_rev;
    wire [DW-1:0] sum_rev;
    wire [DW-1:0] brev_next;
    genvar gi;
    generate
        for (gi = 0; gi < DW; gi = gi + 1) begin : g_rev
            assign ptr_rev[gi]   = I_WR_PTR[DW-1-gi];
            assign piv_rev[gi]   = pivot_bytes[DW-1-gi];
            assign brev_next[gi] = sum_rev[DW-1-gi];
        end
    endgenerate
    assign sum_rev = ptr_rev + piv_rev;

    wire [DW-1:0] brev_addr = {brev_next[DW-1:1], 1'b0};
    wire [DW-1:0] norm_next = I_WR_PTR + I_WR_OFFSET;

    // X write unit; only this unit ever sees reversed addresses
    always @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            O_WR_VALID     <= 1'b0;
            O_WR_EA        <= {DW{1'b0}};
            O_WR_PTR_NEXT  <= {DW{1'b0}};
            O_WR_BITREV    <= 1'b0;
            O_WR_MOD_ALLOW <= 1'b0;
        end else begin
            O_WR_VALID  <= I_WR_REQ;
            O_WR_BITREV <= I_WR_REQ & brev_active;
            // Reversal wins over modulo on writes
            O_WR_MOD_ALLOW <= I_WR_REQ & mode_ctl_q[`BRAGU_MODE_XMODEN] & ~brev_active;
            if (brev_active) begin
                O_WR_PTR_NEXT <= {brev_next[DW-1:1], 1'b0};
                O_WR_EA       <= is_pre ? brev_addr : {I_WR_PTR[DW-1:1], 1'b0};
            end else begin
                O_WR_PTR_NEXT <= (I_WR_MODE == `BRAGU_AM_DIRECT) ? I_WR_PTR : norm_next;
                O_WR_EA       <= is_pre | (I_WR_MODE == `BRAGU_AM_INDEXED) ? norm_next : I_WR_PTR;
            end
        end
    end

    // X read unit: normal addresses only, modulo still permitted
    always @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            O_RD_VALID     <= 1'b0;
            O_RD_EA        <= {DW{1'b0}};
            O_RD_MOD_ALLOW <= 1'b0;
        end else begin
            O_RD_VALID     <= I_RD_REQ;
            O_RD_EA        <= I_RD_PTR + I_RD_OFFSET;
            O_RD_MOD_ALLOW <= I_RD_REQ & mode_ctl_q[`BRAGU_MODE_XMODEN];
        end
    end

    // Table address: page byte joined to full EA, no alignment forced
    always @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            O_TBL_VALID  <= 1'b0;
            O_TBL_ADDR   <= {PW{1'b0}};
            O_TBL_CONFIG <= 1'b0;
            O_TBL_WRITE  <= 1'b0;
        end else begin
            O_TBL_VALID  <= I_TBL_REQ;
            O_TBL_ADDR   <= {table_page_q, I_TBL_EA};
            O_TBL_CONFIG <= table_page_q[`BRAGU_PAGE_SPACE_BIT];
            O_TBL_WRITE  <= I_TBL_REQ & I_TBL_WRITE;
        end
    end

    // Visibility window; writes are refused and counted, never issued
    wire win_hit = I_WIN_REQ & I_WIN_ENABLE & I_WIN_EA[DW-1];
    always @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            O_WIN_VALID   <= 1'b0;
            O_WIN_ADDR    <= {(PW-1){1'b0}};
            O_WIN_WR_ERR  <= 1'b0;
            win_err_cnt_q <= 8'h00;
        end else begin
            O_WIN_VALID  <= win_hit & ~I_WIN_WRITE;
            O_WIN_WR_ERR <= win_hit & I_WIN_WRITE;
            // EA bit 15 is dropped; page bit 0 becomes address bit 15
            O_WIN_ADDR   <= {vis_page_q, I_WIN_EA[`BRAGU_WIN_EA_MSB:1], 1'b0};
            // Count saturates so a flood of bad writes cannot wrap to zero
            if (win_hit & I_WIN_WRITE & (win_err_cnt_q != `BRAGU_ERR_CNT_MAX))
                win_err_cnt_q <= win_err_cnt_q + 8'h01;
        end
    end

    // Table read lane mapping
    reg [DW-1:0] trd_d;
    always @* begin
        trd_d = {DW{1'b0}};
        if (!I_TRD_HIGH) begin
            if (!I_TRD_BYTE)
                trd_d = I_TRD_PWORD[15:0];
            else
                trd_d = {8'h00, I_TRD_BSEL ? I_TRD_PWORD[15:8] : I_TRD_PWORD[7:0]};
        end else begin
            if (!I_TRD_BYTE)
                trd_d = {8'h00, I_TRD_PWORD[23:16]};
            else
                trd_d = I_TRD_BSEL ? {DW{1'b0}} : {8'h00, I_TRD_PWORD[23:16]};
        end
    end

    always @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            O_TRD_VALID <= 1'b0;
            O_TRD_DATA  <= {DW{1'b0}};
        end else begin
            O_TRD_VALID <= I_TRD_REQ;
            O_TRD_DATA  <= trd_d;
        end
    end

    // Program counter steps by two so word addresses match data space
    always @(posedge I_CORE_CLK) begin
        if (I_SRST)
            O_PC <= {PW{1'b0}};
        else if (I_PC_LOAD)
            O_PC <= {I_PC_LOAD_VAL[PW-1:1], 1'b0};
        else if (I_PC_STEP)
            O_PC <= O_PC + {{(PW-2){1'b0}}, 2'b10};
    end

endmodule // bragu_top

// file: bragu_props.sv
// Port-level checks for the address unit.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module bragu_props (
    input wire        I_CORE_CLK,
    input wire        I_SRST,
    input wire        I_WR_REQ,
    input wire        I_WR_BYTE,
    input wire [3:0]  I_WR_PTR_SEL,
    input wire        O_WR_VALID,
    input wire        O_WR_BITREV,
    input wire [15:0] O_WR_EA,
    input wire        O_WR_MOD_ALLOW,
    input wire        I_TBL_REQ,
    input wire [15:0] I_TBL_EA,
    input wire [23:0] O_TBL_ADDR,
    input wire        O_TBL_CONFIG,
    input wire        I_WIN_REQ,
    input wire        I_WIN_WRITE,
    input wire        I_WIN_ENABLE,
    input wire [15:0] I_WIN_EA,
    input wire        O_WIN_VALID,
    input wire        O_WIN_WR_ERR,
    input wire        I_PC_LOAD,
    input wire        I_PC_STEP,
    input wire [23:0] O_PC
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_SRST);
    // Write unit: when reversal may act and what it does to the address
    chk_byte_plain: assert property (I_WR_REQ && I_WR_BYTE |=> O_WR_VALID && !O_WR_BITREV)
        else $error("byte write reversed");
    chk_sel_none: assert property (I_WR_REQ && I_WR_PTR_SEL == 4'hf |=> !O_WR_BITREV)
        else $error("pointer fifteen reversed");
    chk_rev_even: assert property (O_WR_VALID && O_WR_BITREV |-> !O_WR_EA[0])
        else $error("reversed address odd");
    chk_rev_nomod: assert property (O_WR_VALID && O_WR_BITREV |-> !O_WR_MOD_ALLOW)
        else $error("modulo left on");
    // Program space address forming
    chk_tbl_low: assert property (I_TBL_REQ |=> O_TBL_ADDR[15:0] == $past(I_TBL_EA))
        else $error("table address low word");
    chk_tbl_space: assert property (I_TBL_REQ |=> O_TBL_CONFIG == O_TBL_ADDR[23])
        else $error("table space select");
    chk_win_ro: assert property (I_WIN_REQ && I_WIN_WRITE && I_WIN_ENABLE && I_WIN_EA[15]
        |=> O_WIN_WR_ERR && !O_WIN_VALID)
        else $error("window write not refused");
    chk_pc_step: assert property (I_PC_STEP && !I_PC_LOAD |=> O_PC == $past(O_PC) + 24'h000002)
        else $error("program counter step");
    // Main scenarios reached
    cover property (O_WR_VALID && O_WR_BITREV);
    cover property (O_WIN_WR_ERR);
    cover property (I_PC_STEP ##2 I_PC_STEP);
endmodule // bragu_props

bind bragu_top bragu_props u_props (.*);

// file: bragu_pmem.sv
// Program memory stand-in on the far side of the table address.
// Assumes the table address holds between requests.
`timescale 1ns/1ps
module bragu_pmem (
    input  wire [23:0] i_addr,
    output wire [23:0] o_pword
);
    // Upper byte mixes address bits so a lane swap cannot go unseen
    assign o_pword = {i_addr[7:0] ^ 8'h3c, i_addr[15:0]};
endmodule // bragu_pmem

// file: bragu_top_test.sv
// Bench for the address unit: APB registers, reversed writes, table and
// window addresses, read lanes and program counter. Zero-wait APB assumed.
`timescale 1ns/1ps
module bragu_top_test;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel, pen, pwr, pready, pslverr, re;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic        wreq, wbyte, wvalid, wbrev, wmod, rreq, rvalid, rmod;
    logic [3:0]  wsel;
    logic [2:0]  wmode;
    logic [15:0] wptr, woff, wea, wnext, rptr, roff, rea, tea, vea, ddata;
    logic        treq, twr, tvalid, tcfg, twro, vreq, vwr, ven, vvalid, verr;
    logic        dreq, dhigh, dbyte, dbsel, dvalid, pload, pstep;
    logic [23:0] taddr, pword, pval, pc;
    logic [22:0] vaddr;
    int          failures = 0;
    int          total_checks = 0;
    int          cycles = 0;

    // Core clock, 4 ns period
    always #2 clk = ~clk;

    bragu_pmem u_pmem (.i_addr(taddr), .o_pword(pword));

    bragu_top uut (
        .I_CORE_CLK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_WR_REQ(wreq), .I_WR_PTR_SEL(wsel), .I_WR_MODE(wmode),
        .I_WR_BYTE(wbyte), .I_WR_PTR(wptr), .I_WR_OFFSET(woff), .O_WR_VALID(wvalid),
        .O_WR_EA(wea), .O_WR_PTR_NEXT(wnext), .O_WR_BITREV(wbrev), .O_WR_MOD_ALLOW(wmod),
        .I_RD_REQ(rreq), .I_RD_PTR(rptr), .I_RD_OFFSET(roff), .O_RD_VALID(rvalid),
        .O_RD_EA(rea), .O_RD_MOD_ALLOW(rmod), .I_TBL_REQ(treq), .I_TBL_WRITE(twr),
        .I_TBL_EA(tea), .O_TBL_VALID(tvalid), .O_TBL_ADDR(taddr), .O_TBL_CONFIG(tcfg),
        .O_TBL_WRITE(twro), .I_WIN_REQ(vreq), .I_WIN_WRITE(vwr), .I_WIN_ENABLE(ven),
        .I_WIN_EA(vea), .O_WIN_VALID(vvalid), .O_WIN_ADDR(vaddr), .O_WIN_WR_ERR(verr),
        .I_TRD_REQ(dreq), .I_TRD_HIGH(dhigh), .I_TRD_BYTE(dbyte), .I_TRD_BSEL(dbsel),
        .I_TRD_PWORD(pword), .O_TRD_VALID(dvalid), .O_TRD_DATA(ddata),
        .I_PC_LOAD(pload), .I_PC_LOAD_VAL(pval), .I_PC_STEP(pstep), .O_PC(pc));

    task automatic chk(input string what, input [31:0] exp, input [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Request held until pready is sampled high, then released
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rq = prdata;
        re = pslverr;
        {psel, pen} <= 2'b00;
    endtask

    // Request taken at one edge; answer looked at mid-way through the next cycle
    task automatic go;
        @(posedge clk);
        {wreq, rreq, treq, vreq, dreq, pload, pstep} <= 7'h00;
        @(negedge clk);
    endtask

    task automatic wr(input logic [3:0] s, input logic [2:0] m, input logic b,
                      input logic [15:0] p, input logic [15:0] o);
        @(posedge clk);
        {wreq, wsel, wmode, wbyte, wptr, woff} <= {1'b1, s, m, b, p, o};
        go();
    endtask

    task automatic t_regs;
        logic [31:0] rv [0:4];
        rv = '{32'h0, 32'h0, 32'h0, 32'h0000000f, 32'h0};
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk("reset value", rv[i], rq);
        end
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped error", 1, re);
        $display("registers done");
    endtask

    task automatic t_bitrev;
        logic [15:0] sq [0:4];
        sq = '{16'h0110, 16'h0108, 16'h0118, 16'h0104, 16'h0114};
        apb(1'b1, 12'h00c, 32'h00008300);
        apb(1'b1, 12'h000, 32'h00008008); // no indirect read follows at once
        for (int i = 0; i < 5; i++) begin
            wr(4'h3, 3'h3, 1'b0, i == 0 ? 16'h0100 : sq[i - 1], 16'h0002);
            chk("reversed ea", sq[i], wea);
            chk("write valid", 1, wvalid);
            chk("reversed flag", 1, wbrev);
            chk("modulo off", 0, wmod);
        end
        wr(4'h3, 3'h2, 1'b0, 16'h0115, 16'h0002);
        chk("post ea", 16'h0114, wea);
        chk("post next", 16'h010c, wnext);
        for (int m = 0; m < 7; m++) begin
            wr(4'h3, 3'(m), 1'b0, 16'h0100, 16'h0002);
            chk("mode flag", m == 2 || m == 3, wbrev);
        end
        wr(4'h3, 3'h3, 1'b1, 16'h0100, 16'h0001);
        chk("byte ea", 16'h0101, wea);
        wr(4'h5, 3'h3, 1'b0, 16'h0100, 16'h0002);
        chk("other pointer", 0, wbrev);
        chk("write modulo", 1, wmod);
        apb(1'b1, 12'h00c, 32'h00008f00);
        wr(4'hf, 3'h3, 1'b0, 16'h0100, 16'h0002);
        chk("select fifteen", 0, wbrev);
        chk("select fifteen ea", 16'h0102, wea);
        apb(1'b1, 12'h00c, 32'h00008300);
        @(posedge clk);
        {rreq, rptr, roff} <= {1'b1, 16'h0200, 16'h0004};
        go();
        chk("read ea", 16'h0204, rea);
        chk("read valid", 1, rvalid);
        chk("read modulo", 1, rmod);
        apb(1'b1, 12'h000, 32'h00000008);
        wr(4'h3, 3'h3, 1'b0, 16'h0100, 16'h0002);
        chk("disabled ea", 16'h0102, wea);
        $display("bit reverse done");
    endtask

    task automatic t_prog;
        logic [2:0]  lc [0:5];
        logic [15:0] le [0:5];
        lc = '{3'h0, 3'h3, 3'h2, 3'h4, 3'h6, 3'h7};
        le = '{16'h4c20, 16'h004c, 16'h0020, 16'h001c, 16'h001c, 16'h0000};
        apb(1'b1, 12'h004, 32'h00000080);
        @(posedge clk);
        {treq, twr, tea} <= {2'b11, 16'h1235};
        go();
        chk("config table", 32'h00801235, {tcfg, taddr[22:0]});
        chk("table valid", 1, tvalid);
        chk("table write", 1, twro);
        apb(1'b1, 12'h004, 32'h00000012);
        @(posedge clk);
        {treq, twr, tea} <= {2'b10, 16'h4c20};
        go();
        chk("user table", 32'h00124c20, {tcfg, taddr[22:0]});
        chk("table read", 0, twro);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            {dreq, dhigh, dbyte, dbsel} <= {1'b1, lc[i]};
            go();
            chk("lane", le[i], ddata & (lc[i][1] ? 16'h00ff : 16'hffff));
            chk("lane valid", 1, dvalid);
        end
        apb(1'b1, 12'h008, 32'h00000003);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            {vreq, vwr, ven, vea} <= {1'b1, 1'(i), 1'b1, 16'h8abc};
            go();
            chk("window", i == 0 ? 32'h00018abc : 32'h00818abc, {verr, vaddr});
            chk("window valid", i == 0, vvalid);
        end
        @(posedge clk);
        {vreq, vwr, ven, vea} <= {1'b1, 1'b0, 1'b1, 16'h0abc};
        go();
        chk("window miss", 0, vvalid);
        apb(1'b0, 12'h010, 32'h0);
        chk("refused count", 1, rq);
        $display("program space done");
    endtask

    task automatic t_pc;
        @(posedge clk);
        {pload, pval} <= {1'b1, 24'h000100};
        go();
        repeat (3) begin
            @(posedge clk);
            pstep <= 1'b1;
            go();
        end
        chk("pc steps", 24'h000106, pc);
        $display("program counter done");
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Hang guard; the run needs about 120 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures = failures + 1;
            finish_test();
        end
    end

    // Inputs idle at time zero, reset held five cycles
    initial begin
        {psel, pen, pwr, paddr, pwdata, wreq, wsel, wmode, wbyte, wptr, woff} = '0;
        {rreq, rptr, roff, treq, twr, tea, vreq, vwr, ven, vea} = '0;
        {dreq, dhigh, dbyte, dbsel, pload, pval, pstep} = '0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_bitrev();
        t_prog();
        t_pc();
        finish_test();
    end
endmodule // bragu_top_test
